//--- rtl/lft_link.sv
// LF transponder link: start-up path, downlink decoder, framer and uplink encoder.
// Assumes a field envelope and the 125 kHz field clock arriving asynchronously,
// and an upstream source supplying response payload bytes on request.
// Notes on behaviour
// [R1] Any reset returns all state to initial values and restarts the start-up path.
// [R2] After the post-reset delay, check the field; if present run transponder path.
// [R3] No field at start-up: exit to application, no transponder initialisation.
// [R4] Enhanced-mode detection step is skipped; it has no effect here.
// [R5] Entering transponder mode sets field ack, low power, boot vectors, watchdog, link.
// [R6] Optional header: Manchester 1010 repeated until the base station makes a gap.
// [R7] Base station keys the field on/off; binary mode gives one bit per pulse.
// [R8] Quad mode decodes each pulse length into two bits.
// [R9] Damped mode: send Manchester zeros; gap in undamped half means one.
// [R10] Uplink damps coil to half amplitude, coded Manchester or biphase.
// [R11] Session is request, two millisecond pause, then response.
// [R12] Base station starts every session; response only after a good request.
// [R13] Any error answers with a fixed one kilohertz damping waveform.
// [R14] Error cause is kept for a later status request.
// [R15] Request starts with a four-bit command and its four-bit check nibble.
// [R16] Payload is optional; its CRC8 byte follows only when payload exists.
// [R17] Every response starts with header byte FE, then payload and CRC8.
// [R18] Uplink select zero is Manchester, one is biphase.
// [R19] Downlink select 00 binary, 01 quad, 10 damped phase.
// [R20] Header enable bit includes the detection header in start-up.
// [R21] Command check or payload CRC mismatch is an error with recorded cause.
`timescale 1ns/10ps
module lft_link import lft_pkg::*; #(
    parameter int unsigned P_BOOT_CYC = BOOT_CYC,
    parameter int unsigned P_TURN_CYC = TURN_CYC,
    parameter int unsigned P_HALF_BIT_CYC = HALF_BIT_CYC,
    parameter int unsigned P_ERR_HALF_CYC = ERR_HALF_CYC,
    parameter int unsigned P_EOF_CYC = EOF_CYC
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Field front end
    input wire logic i_field,
    input wire logic i_lf_clk,
    output logic o_damp,
    // Configuration
    input wire lft_cfg_type i_cfg,
    // Start-up result
    output lft_mode_type o_mode,
    output logic o_app_exit,
    // Request side
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte,
    output logic o_req_valid,
    output lft_req_type o_req,
    output logic [7:0] o_status,
    // Response side
    input wire logic i_rsp_valid,
    input wire lft_rsp_type i_rsp,
    output logic o_rsp_ready
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [TMR_W-1:0] t, input int unsigned n);
        return t == TMR_W'(n - 1);
    endfunction

    function automatic logic [3:0] command_check_nibble(input logic [3:0] d);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 3; i >= 0; i--) begin
            c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? COMMAND_CHECK_NIBBLE_POLY : 4'h0);
        end
        return c;
    endfunction

    function automatic logic [7:0] crc8(input logic [7:0] c0, input logic [7:0] d);
        logic [7:0] c;
        c = c0;
        for (int i = 7; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC8_POLY : 8'h00);
        end
        return c;
    endfunction

    function automatic logic [1:0] plm_dec(input logic [9:0] len, input logic [7:0] thr,
                                           input logic quad);
        logic [9:0] t;
        t = {2'b00, thr};
        if (!quad) begin
            plm_dec = {1'b0, len > t};
        end else if (len < t) begin
            plm_dec = 2'b00;
        end else if (len < (t << 1)) begin
            plm_dec = 2'b01;
        end else if (len < 10'(t * 3)) begin
            plm_dec = 2'b10;
        end else begin
            plm_dec = 2'b11;
        end
    endfunction

    // Next coil level for the half bit now starting
    function automatic logic ul_level(input logic biph, input logic b, input logic ph,
                                      input logic cur);
        if (!biph) begin
            return ph ? ~b : b;
        end
        return ph ? (b ? cur : ~cur) : ~cur;
    endfunction

    function automatic lft_st_type rx_clear(input lft_st_type s);
        lft_st_type r;
        r = s;
        r.state = ST_RX;
        r.first = 1'b1;
        r.sof = 1'b0;
        r.gap = 1'b0;
        r.nbit = 3'h0;
        r.nbytes = 8'h00;
        r.crc = CRC8_INIT;
        r.err = ERR_NONE;
        r.plen = 10'h000;
        r.tmr = '0;
        r.hb = '0;
        r.ph = 1'b0;
        r.damp = 1'b0;
        return r;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] fs_r;
    logic [1:0] lfs_r;
    logic fld_d_r;
    logic lf_d_r;
    logic fld;
    logic fld_fall;
    logic lf_rise;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fs_r <= 2'b00;
            lfs_r <= 2'b00;
            fld_d_r <= 1'b0;
            lf_d_r <= 1'b0;
        end else begin
            fs_r <= {fs_r[0], i_field};
            lfs_r <= {lfs_r[0], i_lf_clk};
            fld_d_r <= fs_r[1];
            lf_d_r <= lfs_r[1];
        end
    end

    assign fld = fs_r[1];
    assign fld_fall = fld_d_r & ~fs_r[1];
    assign lf_rise = lfs_r[1] & ~lf_d_r;

    // ------------------------------------------------------------
    // Link controller
    // ------------------------------------------------------------
    lft_st_type st_r;
    lft_st_type st_nxt;
    logic hb_tick;
    logic push;
    logic k2;
    logic [1:0] v;
    logic [7:0] b;
    logic [3:0] cnt;
    logic [3:0] e;

    assign hb_tick = hit(st_r.hb, P_HALF_BIT_CYC);

    always_comb begin
        st_nxt = st_r;
        push = 1'b0;
        k2 = 1'b0;
        v = 2'b00;
        b = 8'h00;
        cnt = 4'h0;
        e = ERR_NONE;
        st_nxt.rx_vld = 1'b0;
        st_nxt.req_vld = 1'b0;
        st_nxt.rsp_rdy = 1'b0;
        st_nxt.hb = hb_tick ? '0 : st_r.hb + 1'b1;
        unique case (st_r.state)
            ST_BOOT: begin
                st_nxt.tmr = st_r.tmr + 1'b1;
                if (hit(st_r.tmr, P_BOOT_CYC)) begin
                    st_nxt.tmr = '0;
                    // Enhanced-mode step skipped (see [R4])
                    st_nxt.state = fld ? ST_INIT : ST_APP; // see [R2]
                    st_nxt.app = ~fld; // see [R3]
                end
            end
            ST_INIT: begin
                st_nxt.mode = '1; // see [R5]
                st_nxt = rx_clear(st_nxt);
                if (i_cfg.detection_header_enable) begin // see [R20]
                    st_nxt.state = ST_HEADER;
                    st_nxt.txsh = HDR_PAT;
                    st_nxt.txcnt = 3'h0;
                end
            end
            ST_HEADER: begin
                if (fld_fall) begin
                    st_nxt = rx_clear(st_nxt); // see [R6]
                end else if (hb_tick) begin
                    st_nxt.damp = ul_level(UL_MANCHESTER, st_r.txsh[7], st_r.ph, st_r.damp);
                    st_nxt.ph = ~st_r.ph;
                    if (st_r.ph) begin
                        st_nxt.txcnt = st_r.txcnt + 1'b1;
                        st_nxt.txsh = (st_r.txcnt == 3'h7) ? HDR_PAT : {st_r.txsh[6:0], 1'b0};
                    end
                end
            end
            ST_RX: begin
                st_nxt.tmr = fld ? st_r.tmr + 1'b1 : '0;
                if (fld && lf_rise && st_r.plen != 10'h3FF) begin
                    st_nxt.plen = st_r.plen + 1'b1;
                end
                if (i_cfg.downlink_coding_select == DAMPED_PHASE_CODING) begin // see [R19]
                    if (fld_fall && st_r.ph) begin
                        st_nxt.gap = 1'b1; // see [R9]
                    end
                    if (hb_tick) begin
                        st_nxt.damp = ul_level(UL_MANCHESTER, 1'b0, st_r.ph, st_r.damp);
                        st_nxt.ph = ~st_r.ph;
                        if (st_r.ph) begin
                            st_nxt.gap = 1'b0;
                            st_nxt.sof = st_r.sof | st_r.gap;
                            push = st_r.sof;
                            v = {1'b0, st_r.gap | (fld_fall & st_r.ph)};
                        end
                    end
                end else if (fld_fall) begin
                    st_nxt.plen = 10'h000;
                    push = st_r.plen != 10'h000; // see [R7]
                    k2 = i_cfg.downlink_coding_select == QUAD_PULSE_LENGTH_CODING;
                    v = plm_dec(st_r.plen, i_cfg.plm_thr, k2); // see [R8]
                end
                if (push) begin
                    b = k2 ? {st_r.sh[5:0], v} : {st_r.sh[6:0], v[0]};
                    cnt = {1'b0, st_r.nbit} + (k2 ? 4'h2 : 4'h1);
                    st_nxt.sh = b;
                    st_nxt.nbit = cnt[2:0];
                    if (cnt[3] && st_r.first) begin
                        st_nxt.first = 1'b0;
                        st_nxt.cmd = b[7:4];
                        if (command_check_nibble(b[7:4]) != b[3:0] && st_r.err == ERR_NONE) begin
                            st_nxt.err = ERR_CMD_CHK; // see [R21]
                        end
                    end else if (cnt[3]) begin
                        st_nxt.rx_vld = 1'b1;
                        st_nxt.rxb = b;
                        st_nxt.crc = crc8(st_r.crc, b); // see [R16]
                        st_nxt.nbytes = st_r.nbytes + 1'b1;
                    end
                end
                if (fld && hit(st_r.tmr, P_EOF_CYC)) begin
                    if (st_r.first) begin
                        st_nxt = rx_clear(st_nxt);
                    end else begin
                        e = st_r.err;
                        if (e == ERR_NONE && st_r.nbit != 3'h0 &&
                            i_cfg.downlink_coding_select != DAMPED_PHASE_CODING) begin
                            e = ERR_FRAME;
                        end else if (e == ERR_NONE && st_r.nbytes != 8'h00 &&
                                     st_r.crc != 8'h00) begin
                            e = ERR_CRC; // see [R21]
                        end
                        st_nxt.err = e;
                        st_nxt.status = {st_r.cmd, e}; // see [R14]
                        st_nxt.req_vld = e == ERR_NONE; // see [R12]
                        st_nxt.state = ST_TURN;
                        st_nxt.tmr = '0;
                        st_nxt.damp = 1'b0;
                    end
                end
            end
            ST_TURN: begin
                st_nxt.tmr = st_r.tmr + 1'b1;
                if (hit(st_r.tmr, P_TURN_CYC)) begin // see [R11]
                    st_nxt.tmr = '0;
                    st_nxt.errcnt = 5'h00;
                    st_nxt.hb = '0;
                    st_nxt.ph = 1'b0;
                    st_nxt.txcnt = 3'h0;
                    st_nxt.txsh = RSP_HDR; // see [R17]
                    st_nxt.src = SRC_HDR;
                    st_nxt.state = (st_r.err == ERR_NONE) ? ST_TX : ST_ERR; // see [R13]
                end
            end
            ST_TX: begin
                if (hb_tick && !st_r.ph && st_r.src == SRC_END) begin
                    // Leave only after the last half bit has run its full length
                    st_nxt = rx_clear(st_nxt);
                end else if (hb_tick) begin
                    // Coil damped to half amplitude while high (see [R10])
                    st_nxt.damp = ul_level(i_cfg.uplink_coding_select, st_r.txsh[7], st_r.ph,
                                           st_r.damp); // see [R18]
                    st_nxt.ph = ~st_r.ph;
                    if (st_r.ph) begin
                        st_nxt.txcnt = st_r.txcnt + 1'b1;
                        st_nxt.txsh = {st_r.txsh[6:0], 1'b0};
                        if (st_r.txcnt == 3'h7) begin
                            if (st_r.src != SRC_CRC && i_rsp_valid &&
                                (st_r.src == SRC_HDR || !st_r.last)) begin
                                st_nxt.txsh = i_rsp.data;
                                st_nxt.last = i_rsp.last;
                                st_nxt.rsp_rdy = 1'b1;
                                st_nxt.src = SRC_PAY;
                                st_nxt.txcrc = crc8((st_r.src == SRC_HDR) ? CRC8_INIT :
                                                    st_r.txcrc, i_rsp.data);
                            end else if (st_r.src == SRC_PAY) begin
                                st_nxt.txsh = st_r.txcrc; // see [R16]
                                st_nxt.src = SRC_CRC;
                            end else begin
                                st_nxt.src = SRC_END;
                            end
                        end
                    end
                end
            end
            ST_ERR: begin
                st_nxt.tmr = st_r.tmr + 1'b1;
                if (hit(st_r.tmr, P_ERR_HALF_CYC)) begin // see [R13]
                    st_nxt.tmr = '0;
                    st_nxt.damp = ~st_r.damp;
                    st_nxt.errcnt = st_r.errcnt + 1'b1;
                    if (st_r.errcnt == ERR_HALVES_LAST) begin
                        st_nxt = rx_clear(st_nxt);
                    end
                end
            end
            ST_APP: begin
                st_nxt.app = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '0; // see [R1]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_damp = st_r.damp;
    assign o_mode = st_r.mode;
    assign o_app_exit = st_r.app;
    assign o_rx_valid = st_r.rx_vld;
    assign o_rx_byte = st_r.rxb;
    assign o_req_valid = st_r.req_vld;
    assign o_req = {st_r.cmd, st_r.nbytes};
    assign o_status = st_r.status;
    assign o_rsp_ready = st_r.rsp_rdy;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    boot_delay_a: assert property ($fell(st_r.state == ST_BOOT) |-> // see [R1]
        $past(st_r.tmr) == TMR_W'(P_BOOT_CYC - 1)) else $error("boot delay wrong");
    field_go_a: assert property (st_r.state == ST_INIT |-> // see [R2]
        $past(st_r.state) == ST_BOOT && $past(fld)) else $error("init without field");
    app_exit_a: assert property ($rose(o_app_exit) |-> // see [R3]
        !$past(fld) && o_mode == '0) else $error("bad application exit");
    mode_set_a: assert property ($rose(o_mode.wdt_on) |-> // see [R5]
        &o_mode && $past(st_r.state) == ST_INIT) else $error("mode flags incomplete");
    hdr_end_a: assert property (st_r.state == ST_HEADER && fld_fall |=> // see [R6]
        st_r.state == ST_RX && !o_damp) else $error("header not ended by gap");
    turn_time_a: assert property (st_r.state != ST_TURN && // see [R11]
        $past(st_r.state) == ST_TURN |->
        $past(st_r.tmr) == TMR_W'(P_TURN_CYC - 1)) else $error("turnaround wrong");
    req_ok_a: assert property (o_req_valid |-> o_status[3:0] == ERR_NONE ##1 // see [R12]
        !o_req_valid) else $error("request flagged with error");
    err_wave_a: assert property (st_r.state == ST_ERR && $changed(o_damp) && // see [R13]
        $past(st_r.state) == ST_ERR |-> $past(st_r.tmr) == TMR_W'(P_ERR_HALF_CYC - 1) &&
        !o_rsp_ready) else $error("error waveform timing");
    cause_kept_a: assert property (st_r.state == ST_TURN && // see [R14]
        $past(st_r.state) == ST_RX |->
        o_status == {st_r.cmd, st_r.err}) else $error("status not recorded");
    hdr_byte_a: assert property (st_r.state == ST_TX && // see [R17]
        $past(st_r.state) == ST_TURN |->
        st_r.txsh == RSP_HDR) else $error("response header wrong");
    manch_mid_a: assert property (st_r.state == ST_TX && hb_tick && st_r.ph && // see [R18]
        i_cfg.uplink_coding_select == UL_MANCHESTER |=> o_damp != $past(o_damp))
        else $error("missing Manchester mid-bit edge");

    hdr_c: cover property (st_r.state == ST_HEADER ##1 st_r.state == ST_RX);
    req_c: cover property (o_req_valid);
    err_c: cover property (st_r.state == ST_ERR);
    app_c: cover property ($rose(o_app_exit));

endmodule

//--- rtl/lft_pkg.sv
// Constants and types for the LF transponder link block.
// Assumes one 100 MHz clock and configuration inputs held stable while the link runs.
package lft_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int BOOT_DLY_US = 100;
    localparam int TURN_US = 2000;
    localparam int HALF_BIT_NS = 128000;
    localparam int ERR_HALF_US = 500;
    localparam int EOF_US = 1000;
    localparam int BOOT_CYC = BOOT_DLY_US * CLK_MHZ;
    localparam int TURN_CYC = TURN_US * CLK_MHZ;
    localparam int HALF_BIT_CYC = HALF_BIT_NS * CLK_MHZ / 1000;
    localparam int ERR_HALF_CYC = ERR_HALF_US * CLK_MHZ;
    localparam int EOF_CYC = EOF_US * CLK_MHZ;
    localparam int ERR_PERIODS = 8;
    localparam logic [4:0] ERR_HALVES_LAST = 5'h0F;
    localparam int TMR_W = 18;

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam logic [7:0] RSP_HDR = 8'hFE;
    localparam logic [7:0] HDR_PAT = 8'hAA;
    localparam logic [3:0] COMMAND_CHECK_NIBBLE_POLY = 4'h3;
    localparam logic [7:0] CRC8_POLY = 8'h07;
    localparam logic [7:0] CRC8_INIT = 8'h00;
    localparam logic UL_MANCHESTER = 1'b0;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_CMD_CHK = 4'h1;
    localparam logic [3:0] ERR_CRC = 4'h2;
    localparam logic [3:0] ERR_FRAME = 4'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BINARY_PULSE_LENGTH_CODING = 2'b00,
        QUAD_PULSE_LENGTH_CODING = 2'b01,
        DAMPED_PHASE_CODING = 2'b10
    } lft_dl_type;

    typedef enum logic [1:0] {
        SRC_HDR = 2'b00, SRC_PAY = 2'b01, SRC_CRC = 2'b10, SRC_END = 2'b11
    } lft_src_type;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000, ST_INIT = 3'b001, ST_HEADER = 3'b010, ST_RX = 3'b011,
        ST_TURN = 3'b100, ST_TX = 3'b101, ST_ERR = 3'b110, ST_APP = 3'b111
    } lft_state_type;

    typedef struct packed {
        logic detection_header_enable;
        logic [1:0] downlink_coding_select;
        logic uplink_coding_select;
        logic [7:0] plm_thr;
    } lft_cfg_type;

    typedef struct packed {
        logic field_ack;
        logic clk_low_power;
        logic vec_boot;
        logic wdt_on;
        logic link_ready;
    } lft_mode_type;

    typedef struct packed {
        logic [3:0] cmd;
        logic [7:0] nbytes;
    } lft_req_type;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } lft_rsp_type;

    typedef struct packed {
        lft_state_type state;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] hb;
        logic ph;
        logic damp;
        logic [7:0] txsh;
        logic [2:0] txcnt;
        lft_src_type src;
        logic last;
        logic [7:0] txcrc;
        logic [9:0] plen;
        logic [7:0] sh;
        logic [2:0] nbit;
        logic first;
        logic sof;
        logic gap;
        logic [3:0] cmd;
        logic [7:0] nbytes;
        logic [7:0] crc;
        logic [3:0] err;
        logic [4:0] errcnt;
        logic [7:0] status;
        logic [7:0] rxb;
        logic rx_vld;
        logic req_vld;
        logic rsp_rdy;
        lft_mode_type mode;
        logic app;
    } lft_st_type;

endpackage

//--- dv/lft_bs_model.sv
// Base station model: keys the LF field and runs the carrier clock.
// Assumes the bench calls its tasks; carrier stands still while the field is off.
`timescale 1ns/10ps
module lft_bs_model (
    output logic o_field,
    output logic o_lf_clk
);
    initial begin
        o_field = 1'b0;
        o_lf_clk = 1'b0;
    end
    always #62.5 o_lf_clk = o_field ? ~o_lf_clk : 1'b0;
    task automatic set_field(input logic on);
        o_field = on;
    endtask
    // Field on for n carrier periods, then a gap
    task automatic burst(input int n);
        o_field = 1'b1;
        #(n * 125.0);
        o_field = 1'b0;
        #400;
    endtask
    // Command byte MSB first; the leading gap opens the request
    task automatic send_cmd(input logic [7:0] b, input logic quad);
        o_field = 1'b0;
        #400;
        for (int i = 7; i >= 0; i -= quad ? 2 : 1) begin
            burst(quad ? 4 + 8 * b[i -: 2] : (b[i] ? 12 : 4));
        end
        o_field = 1'b1;
    endtask
endmodule

//--- dv/tb_lft_link.sv
// Bench for the LF link: start-up paths, request decode, response and error.
// Assumes the base station model drives the field; response source idle.
`timescale 1ns/10ps
module tb_lft_link import lft_pkg::*;;
    typedef struct packed {
        logic [1:0] dl;
        logic fld;
        logic [7:0] cmd;
        logic ok;
        logic [7:0] stat;
    } lft_row_type;
    localparam int P_TURN = 50;
    localparam int P_HALF = 8;
    localparam lft_row_type ROWS [5] = '{
        '{2'b00, 1'b1, 8'h00, 1'b1, 8'h00},
        '{2'b00, 1'b1, 8'h26, 1'b1, 8'h20},
        '{2'b01, 1'b1, 8'h13, 1'b1, 8'h10},
        '{2'b00, 1'b1, 8'h25, 1'b0, 8'h21},
        '{2'b00, 1'b0, 8'h00, 1'b0, 8'h00}
    };
    logic clk;
    logic rst_n = 1'b0;
    lft_cfg_type cfg = '0;
    logic field;
    logic lf_clk;
    logic damp;
    lft_mode_type mode;
    logic app_exit;
    logic req_valid;
    lft_req_type req;
    logic [7:0] status;
    int err_count = 0;
    int comparisons = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    lft_bs_model u_bs (.o_field(field), .o_lf_clk(lf_clk));
    lft_link #(.P_BOOT_CYC(20), .P_TURN_CYC(P_TURN), .P_HALF_BIT_CYC(P_HALF),
        .P_ERR_HALF_CYC(10), .P_EOF_CYC(500)) u_dut (
        .i_ref_clk(clk), .i_rstn(rst_n), .i_field(field), .i_lf_clk(lf_clk),
        .o_damp(damp), .i_cfg(cfg), .o_mode(mode), .o_app_exit(app_exit),
        .o_rx_valid(), .o_rx_byte(), .o_req_valid(req_valid), .o_req(req),
        .o_status(status), .i_rsp_valid(1'b0), .i_rsp('0), .o_rsp_ready());
    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_cnt(input string nm, input int lo, input int hi, input int g);
        comparisons++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [15:0] manch(input logic [7:0] b);
        logic [15:0] m;
        for (int i = 0; i < 8; i++) m[2*i +: 2] = {b[i], ~b[i]};
        return m;
    endfunction
    // ------------------------------------------------------------
    // One reset and start-up per row; a session only for rows with the field on
    // ------------------------------------------------------------
    task automatic run_row(input lft_row_type r);
        int t_req;
        int t_rise;
        int n;
        logic prev;
        logic [15:0] hv;
        @(posedge clk);
        rst_n <= 1'b0;
        cfg <= '{1'b1, r.dl, UL_MANCHESTER, 8'h08};
        u_bs.set_field(r.fld);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        #1;
        chk_val("app_exit", {15'h0, ~r.fld}, {15'h0, app_exit});
        chk_val("mode", r.fld ? 16'h1F : 16'h0, {11'h0, mode});
        if (r.fld) begin
            n = 0;
            prev = damp;
            repeat (200) begin
                @(posedge clk);
                #1;
                n += int'(damp !== prev);
                prev = damp;
            end
            chk_cnt("header toggles", 6, 30, n);
            u_bs.send_cmd(r.cmd, r.dl[0]);
            prev = damp;
            t_req = -1;
            t_rise = -1;
            n = 0;
            hv = '0;
            for (int c = 0; c < 1500; c++) begin
                @(posedge clk);
                #1;
                if (req_valid === 1'b1) t_req = c;
                if (damp !== prev) begin
                    n++;
                    if (t_rise < 0 && t_req >= 0) t_rise = c;
                end
                if (t_rise >= 0 && c - t_rise < 128 && (c - t_rise) % 8 == 4)
                    hv[15 - (c - t_rise) / 8] = damp;
                prev = damp;
            end
            chk_val("req_valid", {15'h0, r.ok}, {15'h0, t_req >= 0});
            chk_val("status", {8'h0, r.stat}, {8'h0, status});
            if (r.ok) begin
                chk_val("req", {4'h0, r.cmd[7:4], 8'h00}, {4'h0, req});
                chk_cnt("turnaround", P_TURN + P_HALF - 3, P_TURN + P_HALF + 4,
                    t_rise - t_req);
                chk_val("response", manch(8'hFE), hv);
            end else begin
                chk_cnt("error toggles", 16, 16, n);
                chk_val("damp idle", 16'h0, {15'h0, damp});
            end
        end
    endtask
    initial begin
        for (int i = 0; i < 5; i++) run_row(ROWS[i]);
        give_verdict();
    end
    initial begin
        #400000;
        err_count++;
        give_verdict();
    end
endmodule
